// ### src/iutbc_defs.vh
// Constants for the trap, boot and cache control block.
`ifndef IUTBC_DEFS_VH
`define IUTBC_DEFS_VH
// APB register byte offsets and field positions.
`define IUTBC_OFF_CTRL    12'h000
`define IUTBC_OFF_STAT    12'h004
`define IUTBC_OFF_TRAP    12'h008
`define IUTBC_OFF_ECC     12'h00c
`define IUTBC_CTRL_FPU    0
`define IUTBC_CTRL_CP     1
`define IUTBC_CTRL_ET     2
`define IUTBC_CTRL_SUP    3
`define IUTBC_CTRL_DBGRES 4
`define IUTBC_CTRL_RST    2'h0
// Boot.
`define IUTBC_BOOT_PC     28'h0000000
`define IUTBC_BOOT_ADDR_MC 3'h3
`define IUTBC_BOOT_CS_MC  3'h4
`define IUTBC_DBG_INSNS   3'h4
`define IUTBC_PW_8        2'h0
`define IUTBC_PW_16       2'h1
`define IUTBC_PW_32       2'h2
// Instruction classes.
`define IUTBC_C_OTHER     4'h0
`define IUTBC_C_JMPL      4'h1
`define IUTBC_C_LDD       4'h2
`define IUTBC_C_ST        4'h3
`define IUTBC_C_STD       4'h4
`define IUTBC_C_LDST      4'h5
`define IUTBC_C_MUL       4'h6
`define IUTBC_C_DIV       4'h7
`define IUTBC_C_FPOP      4'h8
`define IUTBC_C_CPOP      4'h9
`define IUTBC_C_SAVE      4'ha
`define IUTBC_C_RESTORE   4'hb
`define IUTBC_C_TICC      4'hc
`define IUTBC_C_UNIMP     4'hd
// Execution cycle counts.
`define IUTBC_CYC_1       6'h01
`define IUTBC_CYC_2       6'h02
`define IUTBC_CYC_3       6'h03
`define IUTBC_CYC_4       6'h04
`define IUTBC_CYC_DIV     6'h23
`define IUTBC_CYC_TRAP    6'h04
// External cause inputs.
`define IUTBC_X_WRERR     0
`define IUTBC_X_IACC      1
`define IUTBC_X_WATCH     2
`define IUTBC_X_ALIGN     3
`define IUTBC_X_FPEXC     4
`define IUTBC_X_DACC      5
`define IUTBC_X_TAG       6
`define IUTBC_X_DIVZ      7
// Trap type codes.
`define IUTBC_TT_RESET    8'h00
`define IUTBC_TT_WRERR    8'h2b
`define IUTBC_TT_IACC     8'h01
`define IUTBC_TT_PRIV     8'h03
`define IUTBC_TT_ILL      8'h02
`define IUTBC_TT_FPDIS    8'h04
`define IUTBC_TT_CPDIS    8'h24
`define IUTBC_TT_WATCH    8'h0b
`define IUTBC_TT_WOVF     8'h05
`define IUTBC_TT_WUNF     8'h06
`define IUTBC_TT_REGHW    8'h20
`define IUTBC_TT_ALIGN    8'h07
`define IUTBC_TT_FPEXC    8'h08
`define IUTBC_TT_DACC     8'h09
`define IUTBC_TT_TAG      8'h0a
`define IUTBC_TT_DIVZ     8'h2a
`define IUTBC_TT_SW       8'h80
`define IUTBC_TT_IRQ      8'h10
`endif

// ### src/iutbc_secded.v
// Register file single-error-correct, double-error-detect checker.
module iutbc_secded (
	input  wire [38:0] cw_in,
	output reg  [31:0] data_out,
	output reg  [38:0] cw_fix,
	output reg         err_single,
	output reg         err_double
);
	reg [5:0] syn;
	reg       par;
	integer   i;
	integer   k;

	// Bits 38..1 are Hamming positions, bit 0 is overall parity.
	always @* begin
		syn = 6'h00;
		par = cw_in[0];
		k = 0;
		data_out = 32'h00000000;
		for (i = 1; i < 39; i = i + 1) begin
			par = par ^ cw_in[i];
			if (cw_in[i])
				syn = syn ^ i[5:0];
		end
		cw_fix = cw_in;
		err_single = par & (syn < 6'd39);
		err_double = ((syn != 6'h00) & ~par) | (par & (syn > 6'd38));
		if (err_single)
			cw_fix[syn] = ~cw_in[syn];
		for (i = 1; i < 39; i = i + 1) begin
			if ((i & (i - 1)) != 0) begin
				data_out[k] = cw_fix[i];
				k = k + 1;
			end
		end
	end
endmodule

// ### src/iutbc_cache_ctl.v
// Cacheability, alternate space decode, LRU choice and parity fallback.
`include "iutbc_defs.vh"
module iutbc_cache_ctl #(
	parameter IDXB = 4
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        acc_valid,
	input  wire        acc_icache,
	input  wire [31:0] acc_addr,
	input  wire [3:0]  acc_asi,
	input  wire        hit,
	input  wire        hit_set,
	input  wire        fill,
	input  wire        par_err,
	output reg         cacheable_q,
	output reg         force_miss_q,
	output reg         upd_hit_q,
	output reg         flush_i_q,
	output reg         flush_d_q,
	output reg         diag_q,
	output reg  [1:0]  diag_sel_q,
	output reg         bypass_q,
	output reg         victim_q
);
	reg  [(2 << IDXB) - 1:0] lru_q;
	wire [IDXB:0]            idx = {acc_icache, acc_addr[IDXB + 4:5]};
	wire                     cach;

	assign cach = ~acc_addr[31] & ~(acc_addr[30:29] == 2'h1);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lru_q <= {(2 << IDXB){1'b0}};
			cacheable_q <= 1'b0;
			force_miss_q <= 1'b0;
			upd_hit_q <= 1'b0;
			flush_i_q <= 1'b0;
			flush_d_q <= 1'b0;
			diag_q <= 1'b0;
			diag_sel_q <= 2'h0;
			bypass_q <= 1'b0;
			victim_q <= 1'b0;
		end else begin
			cacheable_q <= acc_valid & cach & ~par_err;
			force_miss_q <= acc_valid & ((acc_asi[3:2] == 2'h0) | (acc_asi == 4'h4) |
				(acc_asi == 4'h7));
			upd_hit_q <= acc_valid & ((acc_asi == 4'h4) | (acc_asi == 4'h7));
			flush_i_q <= acc_valid & (acc_asi == 4'h5);
			flush_d_q <= acc_valid & (acc_asi == 4'h6);
			diag_q <= acc_valid & (acc_asi[3:2] == 2'h3);
			diag_sel_q <= acc_asi[1:0];
			bypass_q <= acc_valid & par_err;
			victim_q <= lru_q[idx];
			if (acc_valid & ~par_err & cach) begin
				if (hit)
					lru_q[idx] <= ~hit_set;
				else if (fill)
					lru_q[idx] <= ~lru_q[idx];
			end
		end
	end
endmodule

// ### src/iutbc_top.v
// Integer unit trap, boot, register file recovery and cache control.
//
// Chosen here: the APB slave port and the placing of the registers.
`include "iutbc_defs.vh"
// Contract
// - Issue takes 2,3,4,35 or 1 cycles by instruction class.
// - Pipeline stalls during FP execution; quad operands are not supported.
// - Debug pins low at reset: normal run from address zero, the PROM.
// - Width strap: 00 is 8-bit, 01 is 16-bit, 1x is 32-bit PROM.
// - Debug pins high: run 4 instructions from zero, then enter debug mode.
// - PROM address 3 memory clocks after reset, select and read one later.
// - Each trap has a fixed code and priority; reset 0x00, write error 0x2B.
// - Unimplemented instruction traps with code 0x02, priority 5.
// - Privileged instruction in user mode traps with 0x03, priority 4.
// - FP disabled traps 0x04, coprocessor disabled 0x24, both priority 6.
// - Window overflow 0x05, underflow 0x06, both priority 8.
// - Misaligned access traps with 0x07, priority 10.
// - Software trap uses code 0x80 to 0xFF, priority 16.
// - Register file words carry a single-correct double-detect Hamming code.
// - Correctable error: halt, write back corrected word, resume same instruction.
// - Uncorrectable register file error traps with code 0x20.
// - Only PROM and RAM regions are cacheable.
// - Alternate space codes select miss, flush, normal or diagnostic access.
// - Both caches replace their least recently used set.
// - Cache parity error discards the copy and reads external memory.
// - Simultaneous traps: only the highest priority one is taken.
// - Reset starts at zero with trap enable clear and supervisor set.
module iutbc_top #(
	parameter [3:0] MCLK_DIV = 4'h2,
	parameter       IDXB     = 4
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        debug_break_pin,
	input  wire        debug_unit_enable_pin,
	input  wire [1:0]  prom_width_strap,
	input  wire [3:0]  prom_bank_size,
	output reg         mem_clk_out,
	output reg  [27:0] prom_addr,
	output reg         prom_addr_valid,
	output reg         prom_cs_n,
	output reg         prom_rd_n,
	output reg  [1:0]  prom_width_sel,
	output reg         debug_mode,
	input  wire        instr_valid,
	input  wire [3:0]  instr_class,
	input  wire        instr_priv,
	input  wire        win_invalid,
	input  wire        fp_quad,
	input  wire        ticc_true,
	input  wire [6:0]  ticc_num,
	input  wire [7:0]  cause_in,
	input  wire [3:0]  irq_level,
	input  wire        fpu_done,
	output wire        instr_ready,
	output reg         fpu_start,
	output reg         trap_taken,
	output reg  [7:0]  trap_type_code,
	output reg         error_mode,
	output reg  [1:0]  processor_state_register,
	input  wire        rf_rd_valid,
	input  wire [7:0]  rf_rd_addr,
	input  wire [38:0] rf_rd_cw,
	output reg         rf_wb_en,
	output reg  [7:0]  rf_wb_addr,
	output reg  [38:0] rf_wb_cw,
	output reg         replay,
	input  wire        acc_valid,
	input  wire        acc_icache,
	input  wire [31:0] acc_addr,
	input  wire [3:0]  acc_asi,
	input  wire        cache_hit,
	input  wire        cache_hit_set,
	input  wire        cache_fill,
	input  wire        cache_par_err,
	output wire        cacheable,
	output wire        force_miss,
	output wire        update_on_hit,
	output wire        flush_icache,
	output wire        flush_dcache,
	output wire        diag_access,
	output wire [1:0]  diag_sel,
	output wire        use_external,
	output wire        victim_set
);
	// ************************************************************
	// Local states and helpers
	// ************************************************************
	localparam [1:0] B_CAP = 2'h0, B_WAIT = 2'h1, B_RUN = 2'h2;
	localparam [1:0] E_IDLE = 2'h0, E_WB = 2'h1, E_RES = 2'h2;

	function [5:0] cycles_for;
		input [3:0] cls;
		begin
			case (cls)
				`IUTBC_C_JMPL, `IUTBC_C_LDD, `IUTBC_C_ST: cycles_for = `IUTBC_CYC_2;
				`IUTBC_C_STD, `IUTBC_C_LDST: cycles_for = `IUTBC_CYC_3;
				`IUTBC_C_MUL: cycles_for = `IUTBC_CYC_4;
				`IUTBC_C_DIV: cycles_for = `IUTBC_CYC_DIV;
				default: cycles_for = `IUTBC_CYC_1;
			endcase
		end
	endfunction

	// Returns {valid, code}; earlier tests win, so the order is the ranking.
	function [8:0] trap_pick;
		input [15:0] c;
		input [6:0]  swn;
		input [3:0]  irq;
		input        et;
		begin
			if (c[0]) trap_pick = {1'b1, `IUTBC_TT_WRERR};
			else if (c[1]) trap_pick = {1'b1, `IUTBC_TT_IACC};
			else if (c[2]) trap_pick = {1'b1, `IUTBC_TT_PRIV};
			else if (c[3]) trap_pick = {1'b1, `IUTBC_TT_ILL};
			else if (c[4]) trap_pick = {1'b1, `IUTBC_TT_FPDIS};
			else if (c[5]) trap_pick = {1'b1, `IUTBC_TT_CPDIS};
			else if (c[6]) trap_pick = {1'b1, `IUTBC_TT_WATCH};
			else if (c[7]) trap_pick = {1'b1, `IUTBC_TT_WOVF};
			else if (c[8]) trap_pick = {1'b1, `IUTBC_TT_WUNF};
			else if (c[9]) trap_pick = {1'b1, `IUTBC_TT_REGHW};
			else if (c[10]) trap_pick = {1'b1, `IUTBC_TT_ALIGN};
			else if (c[11]) trap_pick = {1'b1, `IUTBC_TT_FPEXC};
			else if (c[12]) trap_pick = {1'b1, `IUTBC_TT_DACC};
			else if (c[13]) trap_pick = {1'b1, `IUTBC_TT_TAG};
			else if (c[14]) trap_pick = {1'b1, `IUTBC_TT_DIVZ};
			else if (c[15]) trap_pick = {1'b1, `IUTBC_TT_SW | {1'b0, swn}};
			else if (et && irq != 4'h0) trap_pick = {1'b1, `IUTBC_TT_IRQ | {4'h0, irq}};
			else trap_pick = 9'h000;
		end
	endfunction

	function reg_hit;
		input [11:0] a;
		begin
			reg_hit = (a == `IUTBC_OFF_CTRL) | (a == `IUTBC_OFF_STAT) |
				(a == `IUTBC_OFF_TRAP) | (a == `IUTBC_OFF_ECC);
		end
	endfunction

	// ************************************************************
	// State
	// ************************************************************
	reg  [3:0]  mclk_cnt_q;
	reg         mclk_en_q;
	reg  [1:0]  boot_q;
	reg  [2:0]  mcyc_q;
	reg         dbg_boot_q;
	reg  [2:0]  dbg_cnt_q;
	reg  [3:0]  bank_q;
	reg  [5:0]  cyc_q;
	reg         fp_busy_q;
	reg  [1:0]  ctrl_q;
	reg  [1:0]  ecc_q;
	reg         rf_uerr_q;
	reg  [15:0] corr_cnt_q;
	reg  [15:0] uerr_cnt_q;
	wire        hold;
	wire        issue;
	wire [15:0] causes;
	wire [8:0]  pick;
	wire [31:0] rf_data;
	wire [38:0] rf_fix;
	wire        rf_single;
	wire        rf_double;
	wire        wr_acc;

	iutbc_secded u_secded (
		.cw_in      (rf_rd_cw),
		.data_out   (rf_data),
		.cw_fix     (rf_fix),
		.err_single (rf_single),
		.err_double (rf_double)
	);

	iutbc_cache_ctl #(
		.IDXB (IDXB)
	) u_cache (
		.pclk         (pclk),
		.presetn      (presetn),
		.acc_valid    (acc_valid),
		.acc_icache   (acc_icache),
		.acc_addr     (acc_addr),
		.acc_asi      (acc_asi),
		.hit          (cache_hit),
		.hit_set      (cache_hit_set),
		.fill         (cache_fill),
		.par_err      (cache_par_err),
		.cacheable_q  (cacheable),
		.force_miss_q (force_miss),
		.upd_hit_q    (update_on_hit),
		.flush_i_q    (flush_icache),
		.flush_d_q    (flush_dcache),
		.diag_q       (diag_access),
		.diag_sel_q   (diag_sel),
		.bypass_q     (use_external),
		.victim_q     (victim_set)
	);

	// ************************************************************
	// Pipeline hold and trap selection
	// ************************************************************
	// Issue hold: busy count, FP, register file recovery, boot, debug and error mode.
	assign hold = (cyc_q != 6'h00) | fp_busy_q | (ecc_q != E_IDLE) | (boot_q != B_RUN) |
		debug_mode | error_mode;
	assign instr_ready = ~hold;
	assign issue = instr_valid & ~hold;

	assign causes = {
		ticc_true & (instr_class == `IUTBC_C_TICC),
		cause_in[`IUTBC_X_DIVZ],
		cause_in[`IUTBC_X_TAG],
		cause_in[`IUTBC_X_DACC],
		cause_in[`IUTBC_X_FPEXC] | (fp_quad & (instr_class == `IUTBC_C_FPOP)),
		cause_in[`IUTBC_X_ALIGN],
		rf_uerr_q,
		win_invalid & (instr_class == `IUTBC_C_RESTORE),
		win_invalid & (instr_class == `IUTBC_C_SAVE),
		cause_in[`IUTBC_X_WATCH],
		~ctrl_q[`IUTBC_CTRL_CP] & (instr_class == `IUTBC_C_CPOP),
		~ctrl_q[`IUTBC_CTRL_FPU] & (instr_class == `IUTBC_C_FPOP),
		instr_class == `IUTBC_C_UNIMP,
		instr_priv & ~processor_state_register[1],
		cause_in[`IUTBC_X_IACC],
		cause_in[`IUTBC_X_WRERR]};

	assign pick = trap_pick(causes, ticc_num, irq_level, processor_state_register[0]);

	// ************************************************************
	// APB slave: zero wait, read data captured in the setup cycle
	// ************************************************************
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~reg_hit(paddr);
	assign wr_acc = psel & penable & pwrite & reg_hit(paddr);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel & ~penable & ~pwrite) begin
			case (paddr)
				`IUTBC_OFF_CTRL: prdata <= {30'h0, ctrl_q};
				`IUTBC_OFF_STAT: prdata <= {18'h0, bank_q, prom_width_sel, error_mode,
					debug_mode, dbg_boot_q, boot_q == B_RUN, fp_busy_q, ecc_q != E_IDLE,
					processor_state_register};
				`IUTBC_OFF_TRAP: prdata <= {24'h0, trap_type_code};
				`IUTBC_OFF_ECC: prdata <= {uerr_cnt_q, corr_cnt_q};
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// ************************************************************
	// Memory clock divider and boot sequence
	// ************************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mclk_cnt_q <= 4'h0;
			mclk_en_q <= 1'b0;
			mem_clk_out <= 1'b0;
		end else begin
			mclk_en_q <= 1'b0;
			if (mclk_cnt_q == MCLK_DIV - 4'h1) begin
				mclk_cnt_q <= 4'h0;
				mclk_en_q <= 1'b1;
			end else begin
				mclk_cnt_q <= mclk_cnt_q + 4'h1;
			end
			if (mclk_cnt_q == 4'h0)
				mem_clk_out <= 1'b1;
			else if (mclk_cnt_q == {1'b0, MCLK_DIV[3:1]})
				mem_clk_out <= 1'b0;
		end
	end

	// Straps are sampled on the first edge after release, never under reset.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_q <= B_CAP;
			mcyc_q <= 3'h0;
			dbg_boot_q <= 1'b0;
			dbg_cnt_q <= 3'h0;
			bank_q <= 4'h0;
			prom_width_sel <= `IUTBC_PW_8;
			prom_addr <= `IUTBC_BOOT_PC;
			prom_addr_valid <= 1'b0;
			prom_cs_n <= 1'b1;
			prom_rd_n <= 1'b1;
			debug_mode <= 1'b0;
		end else begin
			case (boot_q)
				B_CAP: begin
					// Boot mode from the debug pins.
					dbg_boot_q <= debug_break_pin & debug_unit_enable_pin;
					bank_q <= prom_bank_size;
					if (prom_width_strap[1])
						prom_width_sel <= `IUTBC_PW_32;
					else if (prom_width_strap[0])
						prom_width_sel <= `IUTBC_PW_16;
					else
						prom_width_sel <= `IUTBC_PW_8;
					boot_q <= B_WAIT;
				end
				B_WAIT: begin
					// Address then select on memory clock steps.
					if (mclk_en_q) begin
						mcyc_q <= mcyc_q + 3'h1;
						if (mcyc_q + 3'h1 == `IUTBC_BOOT_ADDR_MC) begin
							prom_addr <= `IUTBC_BOOT_PC;
							prom_addr_valid <= 1'b1;
						end
						if (mcyc_q + 3'h1 == `IUTBC_BOOT_CS_MC) begin
							prom_cs_n <= 1'b0;
							prom_rd_n <= 1'b0;
							boot_q <= B_RUN;
						end
					end
				end
				B_RUN: begin
					if (dbg_boot_q & issue & (dbg_cnt_q != `IUTBC_DBG_INSNS)) begin
						dbg_cnt_q <= dbg_cnt_q + 3'h1;
						if (dbg_cnt_q + 3'h1 == `IUTBC_DBG_INSNS)
							debug_mode <= 1'b1;
					end
					if (wr_acc & (paddr == `IUTBC_OFF_CTRL) & pwdata[`IUTBC_CTRL_DBGRES])
						debug_mode <= 1'b0;
				end
				default: boot_q <= B_CAP;
			endcase
		end
	end

	// ************************************************************
	// Issue timing, traps and processor state
	// ************************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc_q <= 6'h00;
			fp_busy_q <= 1'b0;
			fpu_start <= 1'b0;
			trap_taken <= 1'b0;
			trap_type_code <= `IUTBC_TT_RESET;
			error_mode <= 1'b0;
			processor_state_register <= 2'h2;
			ctrl_q <= `IUTBC_CTRL_RST;
		end else begin
			fpu_start <= 1'b0;
			trap_taken <= 1'b0;
			if (cyc_q != 6'h00)
				cyc_q <= cyc_q - 6'h01;
			if (fpu_done)
				fp_busy_q <= 1'b0;
			if (wr_acc & (paddr == `IUTBC_OFF_CTRL)) begin
				ctrl_q <= {pwdata[`IUTBC_CTRL_CP], pwdata[`IUTBC_CTRL_FPU]};
				processor_state_register <= {pwdata[`IUTBC_CTRL_SUP], pwdata[`IUTBC_CTRL_ET]};
			end
			if (issue) begin
				if (pick[8]) begin
					if (processor_state_register[0]) begin
						trap_taken <= 1'b1;
						trap_type_code <= pick[7:0];
						processor_state_register <= 2'h2;
						cyc_q <= `IUTBC_CYC_TRAP - 6'h01;
					end else begin
						// A trap with traps disabled stops the core.
						error_mode <= 1'b1;
						trap_type_code <= pick[7:0];
					end
				end else begin
					cyc_q <= cycles_for(instr_class) - 6'h01;
					if (instr_class == `IUTBC_C_FPOP) begin
						fp_busy_q <= 1'b1;
						fpu_start <= 1'b1;
					end
				end
			end
		end
	end

	// ************************************************************
	// Register file error recovery
	// ************************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ecc_q <= E_IDLE;
			rf_wb_en <= 1'b0;
			rf_wb_addr <= 8'h00;
			rf_wb_cw <= 39'h0;
			replay <= 1'b0;
			rf_uerr_q <= 1'b0;
			corr_cnt_q <= 16'h0000;
			uerr_cnt_q <= 16'h0000;
		end else begin
			rf_wb_en <= 1'b0;
			replay <= 1'b0;
			// Pending uncorrectable error; a new one wins over the clear.
			rf_uerr_q <= (rf_rd_valid & rf_double) | (rf_uerr_q & ~issue);
			if (wr_acc & (paddr == `IUTBC_OFF_ECC)) begin
				corr_cnt_q <= 16'h0000;
				uerr_cnt_q <= 16'h0000;
			end
			if (rf_rd_valid & rf_double)
				uerr_cnt_q <= uerr_cnt_q + 16'h0001;
			case (ecc_q)
				E_IDLE: begin
					// Halt and write back the corrected word.
					if (rf_rd_valid & rf_single) begin
						rf_wb_addr <= rf_rd_addr;
						rf_wb_cw <= rf_fix;
						rf_wb_en <= 1'b1;
						corr_cnt_q <= corr_cnt_q + 16'h0001;
						ecc_q <= E_WB;
					end
				end
				E_WB: ecc_q <= E_RES;
				E_RES: begin
					replay <= 1'b1;
					ecc_q <= E_IDLE;
				end
				default: ecc_q <= E_IDLE;
			endcase
		end
	end
endmodule

// ### verification/iutbc_props.sv
// Concurrent checks on the trap, boot and cache control block.
module iutbc_props (
	input logic        pclk,
	input logic        presetn,
	input logic        instr_valid,
	input logic        instr_ready,
	input logic [3:0]  instr_class,
	input logic [7:0]  cause_in,
	input logic        instr_priv,
	input logic [3:0]  irq_level,
	input logic        trap_taken,
	input logic [7:0]  trap_type_code,
	input logic        fpu_start,
	input logic        fpu_done,
	input logic        prom_addr_valid,
	input logic        prom_cs_n,
	input logic        prom_rd_n,
	input logic [7:0]  rf_rd_addr,
	input logic        rf_wb_en,
	input logic [7:0]  rf_wb_addr,
	input logic        replay,
	input logic        acc_valid,
	input logic [31:0] acc_addr,
	input logic [3:0]  acc_asi,
	input logic        cacheable,
	input logic        flush_icache,
	input logic        flush_dcache
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// An issue with no cause_in bit, privilege or interrupt level, so the class alone sets the stall.
	sequence s_clean;
		instr_valid && instr_ready && cause_in == 8'h00 && !instr_priv && irq_level == 4'h0;
	endsequence
	sequence s_sel_low;
		!prom_cs_n && !prom_rd_n;
	endsequence
	a_mul_cycles: assert property (s_clean ##0 instr_class == 4'h6 |=>
		!instr_ready [*3] ##1 instr_ready) else $error("multiply stall wrong");
	a_fp_stall: assert property ((fpu_start || fpu_done) |-> !instr_ready)
		else $error("issue open during fp op");
	a_boot_seq: assert property ($rose(prom_addr_valid) |-> prom_cs_n [*2] ##1 s_sel_low)
		else $error("prom select timing wrong");
	a_wrerr_first: assert property (instr_valid && instr_ready && cause_in[0] |=>
		trap_taken && trap_type_code == 8'h2b) else $error("write error not first");
	a_ill_code: assert property (s_clean ##0 instr_class == 4'hd |=>
		trap_taken && trap_type_code == 8'h02) else $error("illegal code wrong");
	a_rf_fix: assert property (rf_wb_en |-> rf_wb_addr == $past(rf_rd_addr) ##2 replay)
		else $error("write back or replay wrong");
	a_io_uncached: assert property (acc_valid && (acc_addr[31] || acc_addr[31:29] == 3'h1)
		|=> !cacheable) else $error("uncached region cached");
	a_asi_flush: assert property (acc_valid && acc_asi == 4'h5 |=>
		flush_icache && !flush_dcache) else $error("flush decode wrong");
endmodule
bind iutbc_top iutbc_props iutbc_props_i (.*);

// ### verification/iutbc_boot_env.sv
// Reset source, strap pins and debug pins in front of the block.
module iutbc_boot_env (
	input  logic       pclk,
	input  logic       rst_req,
	input  logic       dbg,
	input  logic [1:0] width,
	output logic       presetn,
	output logic       debug_break_pin,
	output logic       debug_unit_enable_pin,
	output logic [1:0] prom_width_strap,
	output logic [3:0] prom_bank_size
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q = 4'h0;
	// Reset is held twelve cycles, above the ten needed.
	always @(posedge pclk) begin
		if (rst_req)
			cnt_q <= 4'hc;
		else if (cnt_q != 4'h0)
			cnt_q <= cnt_q - 4'h1;
	end
	assign presetn = cnt_q == 4'h0 && !rst_req;
	assign debug_break_pin = dbg;
	assign debug_unit_enable_pin = dbg;
	assign prom_width_strap = width;
	// Bank size is settled before the boot begins.
	assign prom_bank_size = {2'h2, width};
endmodule

// ### verification/tb_iu_trap_boot_cache_control.sv
// Self-checking bench for the trap, boot and cache control block.
module tb_iu_trap_boot_cache_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, psel = 0, penable = 0, pwrite = 0, rst_req = 1, dbg = 0, e, tk;
	logic instr_valid = 0, instr_priv = 0, win_invalid = 0, fp_quad = 0, ticc_true = 0;
	logic fpu_done = 0, rf_rd_valid = 0, acc_valid = 0, acc_icache = 0, cache_hit = 1;
	logic cache_hit_set = 0, cache_fill = 0, cache_par_err = 0, presetn, pready, pslverr;
	logic debug_break_pin, debug_unit_enable_pin, mem_clk_out, prom_addr_valid, prom_cs_n;
	logic prom_rd_n, debug_mode, instr_ready, fpu_start, trap_taken, error_mode, rf_wb_en;
	logic replay, cacheable, force_miss, update_on_hit, flush_icache, flush_dcache;
	logic diag_access, use_external, victim_set;
	logic [1:0] width = 2'h2, prom_width_strap, prom_width_sel, processor_state_register;
	logic [1:0] diag_sel;
	logic [3:0] instr_class = '0, irq_level = '0, acc_asi = '0, prom_bank_size;
	logic [6:0] ticc_num = 7'h5a;
	logic [7:0] cause_in = '0, rf_rd_addr = '0, trap_type_code, rf_wb_addr;
	logic [11:0] paddr = '0;
	logic [27:0] prom_addr;
	logic [31:0] pwdata = '0, acc_addr = '0, r, prdata;
	logic [38:0] rf_rd_cw = '0, rf_wb_cw;
	int n_fail = 0, comparisons = 0, cyc = 0, n, i;
	int ncyc[8] = '{1, 2, 2, 2, 3, 3, 4, 35};
	iutbc_top iutbc_top_i (.*);
	iutbc_boot_env iutbc_boot_env_i (.*);
	always #25 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			finish_test;
		end
	end
	task finish_test;
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [38:0] got, input logic [38:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task wr(input logic [3:0] k);
		apb(1'h1, 12'h000, {28'h0, k});
	endtask
	// Ready is combinational, so it is only judged at the falling edge.
	task issue(input logic [3:0] c);
		@(posedge pclk);
		instr_valid <= 1'h1;
		instr_class <= c;
		do @(negedge pclk); while (instr_ready !== 1'h1);
		@(posedge pclk);
		instr_valid <= 1'h0;
		n = 1;
		@(negedge pclk);
		tk = trap_taken;
		while (instr_ready !== 1'h1 && n < 40) begin
			n++;
			@(negedge pclk);
		end
	endtask
	task t_boot(input logic [1:0] w, input logic d);
		@(posedge pclk);
		width <= w;
		dbg <= d;
		rst_req <= 1'h1;
		@(posedge pclk);
		rst_req <= 1'h0;
		repeat (2) @(posedge pclk);
		do @(negedge pclk); while (prom_cs_n !== 1'h0);
		chk(prom_addr, '0);
		chk(processor_state_register, 2'h2);
		chk(trap_type_code, 8'h00);
		chk(prom_width_sel, w[1] ? 2'h2 : w);
		apb(1'h0, 12'h004, '0);
		chk(r[9:8], w[1] ? 2'h2 : w);
	endtask
	task t_trap(input logic [3:0] c, input logic [7:0] x, input logic [3:0] q,
		input logic [1:0] pw, input logic [3:0] k, input logic [7:0] ex);
		wr(k);
		instr_priv <= pw[0];
		win_invalid <= pw[1];
		cause_in <= x;
		irq_level <= q;
		ticc_true <= c == 4'hc;
		issue(c);
		chk(tk, 1'h1);
		chk(trap_type_code, ex);
		chk(n, 4);
	endtask
	task t_fp;
		wr(4'h1);
		fork
			issue(4'h8);
			begin
				repeat (8) @(posedge pclk);
				fpu_done <= 1'h1;
				@(posedge pclk);
				fpu_done <= 1'h0;
			end
		join
		chk(n > 6, 1'h1);
		fp_quad <= 1'h1;
		t_trap(4'h8, 8'h0, 4'h0, 2'h0, 4'hd, 8'h08);
		fp_quad <= 1'h0;
	endtask
	task t_rf;
		@(posedge pclk);
		rf_rd_valid <= 1'h1;
		rf_rd_addr <= 8'h2c;
		rf_rd_cw <= 39'h20;
		@(posedge pclk);
		rf_rd_valid <= 1'h0;
		@(negedge pclk);
		chk(rf_wb_en, 1'h1);
		chk(rf_wb_cw, 39'h0);
		repeat (4) @(posedge pclk);
		apb(1'h0, 12'h00c, '0);
		chk(r[15:0], 16'h1);
		@(posedge pclk);
		rf_rd_valid <= 1'h1;
		rf_rd_cw <= 39'h220;
		@(posedge pclk);
		rf_rd_valid <= 1'h0;
		t_trap(4'h0, 8'h0, 4'h0, 2'h0, 4'hc, 8'h20);
	endtask
	task t_cache;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			acc_valid <= 1'h1;
			acc_asi <= i[3:0];
			acc_addr <= {i[2:0], 29'h0};
			cache_hit_set <= i[0];
			cache_par_err <= i == 8;
			@(posedge pclk);
			@(negedge pclk);
			chk(cacheable, (i[2:0] == 3'h0 || i[2:1] == 2'h1) && i != 8);
			chk({force_miss, update_on_hit, flush_icache, flush_dcache, diag_access},
				{i < 5 || i == 7, i == 4 || i == 7, i == 5, i == 6, i > 11});
			if (i == 8)
				chk(use_external, 1'h1);
			if (i > 9 && i < 12)
				chk(victim_set, i[0]);
		end
		acc_valid <= 1'h0;
	endtask
	initial begin
		for (i = 0; i < 4; i++)
			t_boot(i[1:0], 1'h0);
		t_boot(2'h2, 1'h1);
		for (i = 0; i < 4; i++) begin
			issue(4'h0);
			chk(debug_mode, i == 3);
		end
		apb(1'h0, 12'h010, '0);
		chk(e, 1'h1);
		t_boot(2'h2, 1'h0);
		for (i = 0; i < 8; i++) begin
			issue(i[3:0]);
			chk(n, ncyc[i]);
		end
		t_fp;
		t_rf;
		t_trap(4'hd, 8'h0, 4'h0, 2'h0, 4'hc, 8'h02);
		t_trap(4'h0, 8'h0, 4'h0, 2'h1, 4'h4, 8'h03);
		t_trap(4'h8, 8'h0, 4'h0, 2'h0, 4'hc, 8'h04);
		t_trap(4'h9, 8'h0, 4'h0, 2'h0, 4'hc, 8'h24);
		t_trap(4'ha, 8'h0, 4'h0, 2'h2, 4'hc, 8'h05);
		t_trap(4'hb, 8'h0, 4'h0, 2'h2, 4'hc, 8'h06);
		t_trap(4'h0, 8'h08, 4'h0, 2'h0, 4'hc, 8'h07);
		t_trap(4'hc, 8'h0, 4'h0, 2'h0, 4'hc, 8'hda);
		t_trap(4'hd, 8'h09, 4'h0, 2'h1, 4'h4, 8'h2b);
		t_trap(4'hd, 8'h08, 4'h0, 2'h1, 4'h4, 8'h03);
		t_trap(4'h0, 8'h0, 4'hf, 2'h0, 4'hc, 8'h1f);
		issue(4'hd);
		chk(error_mode, 1'h1);
		t_cache;
		finish_test;
	end
endmodule
